/* File: shared/pfc_regs.vh */
`ifndef PFC_REGS_VH
`define PFC_REGS_VH
// Code-groups
`define PFC_CG_IDLE 5'h1F
`define PFC_CG_SSD1 5'h18
`define PFC_CG_SSD2 5'h11
`define PFC_CG_ESD1 5'h0D
`define PFC_CG_ESD2 5'h07
`define PFC_CG_TXERR 5'h04
// Nibble sent on SSD and on bad SSD
`define PFC_NIB_SSD 4'h5
`define PFC_NIB_BADSSD 4'hE
// Default addresses for strap 0; strap adds one
`define PFC_ADDR_VPHY 5'h00
`define PFC_ADDR_P1 5'h01
`define PFC_ADDR_P2 5'h02
// Idle count that ends carrier
`define PFC_IDLE_END 2'h2
`endif

/* File: src/pfc_buf2.v */
`timescale 1ns/1ps
`default_nettype none
module pfc_buf2 #(
  parameter W = 6
) (
  input wire clk, // Clock
  input wire rst, // Async reset
  input wire [W-1:0] in_data, // Write data
  input wire in_valid, // Write valid
  output wire in_ready, // Space free
  output wire [W-1:0] out_data, // Read data
  output wire out_valid, // Data held
  input wire out_ready // Reader takes
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: src/pfc_codec.v */
// Operation
// - Nibbles map to fixed code-groups, both ways.
// - 11111 is idle, sent between frames.
// - 11000 valid only after idle.
// - 10001 valid only after 11000.
// - TXEN rise sends 11000 then 10001.
// - TXEN fall sends 01101 then 00111.
// - 00111 ends stream only after 01101.
// - TXER sends 00100 instead of data.
// - Invalid groups never sent; flagged in frame.
// - Strap picks default addresses 0/1/2 or 1/2/3.
// - Port addresses writable at run time.
// - Duplicate addresses accepted without check.
// - Strap latched when reset releases.
// - Port 1 datapath only in internal mode.
// - Bad SSD gives error and 1110.
// - ESD or two idles drop carrier.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_regs.vh"
module pfc_codec #(
  parameter PORT_ONE = 1 // 1 when this instance serves port 1
) (
  input wire clk, // 200 MHz clock
  input wire rst, // Async reset, high
  input wire addr_strap_pin, // Address-select strap
  input wire internal_phy_mode, // Port 1 in internal mode
  input wire tx_en, // MAC transmit enable
  input wire tx_er, // MAC transmit error
  input wire [3:0] tx_nibble, // MAC transmit nibble
  output reg tx_ready, // Encoder accepts nibble
  output reg [4:0] tx_group, // Code-group out
  output reg tx_group_valid, // Code-group valid
  input wire tx_group_ready, // Line takes group
  input wire [4:0] rx_group, // Received code-group
  input wire rx_group_valid, // Received valid
  output reg [3:0] rx_nibble, // MII receive nibble
  output reg rx_dv, // Receive data valid
  output reg rx_er, // Receive error
  output reg crs, // Carrier sense
  input wire addr_wr_p1, // Write port 1 address
  input wire addr_wr_p2, // Write port 2 address
  input wire [4:0] addr_wdata, // Address to write
  output reg [4:0] vphy_addr, // Virtual PHY address
  output reg [4:0] p1_addr, // Port 1 address
  output reg [4:0] p2_addr, // Port 2 address
  output reg path_active // Datapath in use
);
  function [4:0] enc;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc = 5'h1E;
        4'h1: enc = 5'h09;
        4'h2: enc = 5'h14;
        4'h3: enc = 5'h15;
        4'h4: enc = 5'h0A;
        4'h5: enc = 5'h0B;
        4'h6: enc = 5'h0E;
        4'h7: enc = 5'h0F;
        4'h8: enc = 5'h12;
        4'h9: enc = 5'h13;
        4'hA: enc = 5'h16;
        4'hB: enc = 5'h17;
        4'hC: enc = 5'h1A;
        4'hD: enc = 5'h1B;
        4'hE: enc = 5'h1C;
        default: enc = 5'h1D;
      endcase
    end
  endfunction
  // Returns {valid, nibble}; anything not a data group is not valid
  function [4:0] dec;
    input [4:0] g;
    begin
      case (g)
        5'h1E: dec = 5'h10;
        5'h09: dec = 5'h11;
        5'h14: dec = 5'h12;
        5'h15: dec = 5'h13;
        5'h0A: dec = 5'h14;
        5'h0B: dec = 5'h15;
        5'h0E: dec = 5'h16;
        5'h0F: dec = 5'h17;
        5'h12: dec = 5'h18;
        5'h13: dec = 5'h19;
        5'h16: dec = 5'h1A;
        5'h17: dec = 5'h1B;
        5'h1A: dec = 5'h1C;
        5'h1B: dec = 5'h1D;
        5'h1C: dec = 5'h1E;
        5'h1D: dec = 5'h1F;
        default: dec = 5'h00;
      endcase
    end
  endfunction

  // Default address: fixed base raised by one when the strap is high
  function [4:0] dflt_addr;
    input [4:0] base;
    input strap;
    begin
      dflt_addr = base + {4'h0, strap};
    end
  endfunction

  // Pin synchronisers: strap and mode pins are not on this clock
  reg strap_s1_q;
  reg strap_s2_q;
  reg mode_s1_q;
  reg mode_s2_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= addr_strap_pin;
      strap_s2_q <= strap_s1_q;
      mode_s1_q <= internal_phy_mode;
      mode_s2_q <= mode_s1_q;
    end
  end
  wire active = (PORT_ONE == 0) || mode_s2_q;
  // Value active takes at the next edge; flops that copy it stay in step
  wire active_d = (PORT_ONE == 0) || mode_s1_q;

  // Strap capture: once, on the third edge after release
  reg [1:0] rel_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rel_q <= 2'h0;
      vphy_addr <= `PFC_ADDR_VPHY;
      p1_addr <= `PFC_ADDR_P1;
      p2_addr <= `PFC_ADDR_P2;
      path_active <= 1'b0;
    end else begin
      path_active <= active_d;
      if (rel_q != 2'h3)
        rel_q <= rel_q + 2'h1;
      // Waits out the synchroniser so the real strap level is held;
      // later strap changes are never looked at again
      if (rel_q == 2'h2) begin
        vphy_addr <= dflt_addr(`PFC_ADDR_VPHY, strap_s2_q);
        p1_addr <= dflt_addr(`PFC_ADDR_P1, strap_s2_q);
        p2_addr <= dflt_addr(`PFC_ADDR_P2, strap_s2_q);
      end else begin
        // No uniqueness check: software owns that
        if (addr_wr_p1)
          p1_addr <= addr_wdata;
        if (addr_wr_p2)
          p2_addr <= addr_wdata;
      end
    end
  end

  // Transmit: one MAC nibble per taken group; delimiters stall the MAC
  localparam TX_IDLE = 5'h01;
  localparam TX_SSD2 = 5'h02;
  localparam TX_DATA = 5'h04;
  localparam TX_ESD1 = 5'h08;
  localparam TX_ESD2 = 5'h10;
  reg [4:0] tx_st_q;
  wire [4:0] b_data;
  wire b_valid, b_in_ready;
  reg [4:0] tx_g;
  reg [4:0] tx_st_d;
  reg push;
  // Buffer level one edge ahead, so tx_ready can come from a flop
  wire take_out = !tx_group_valid || tx_group_ready;
  wire pop_now = b_valid && take_out;
  wire full_next = !pop_now && (!b_in_ready || (b_valid && push));
  always @(posedge clk or posedge rst) begin
    if (rst)
      tx_ready <= 1'b0;
    else
      tx_ready <= (tx_st_d == TX_DATA) && active_d && !full_next;
  end
  // While active, every free slot gets a group, so idle flows while no frame is sent
  always @* begin
    tx_g = `PFC_CG_IDLE;
    tx_st_d = tx_st_q;
    push = 1'b0;
    if (b_in_ready && active) begin
      case (tx_st_q)
        TX_IDLE: begin
          push = 1'b1;
          if (tx_en) begin
            tx_g = `PFC_CG_SSD1;
            tx_st_d = TX_SSD2;
          end
        end
        TX_SSD2: begin
          push = 1'b1;
          tx_g = `PFC_CG_SSD2;
          tx_st_d = TX_DATA;
        end
        TX_DATA: begin
          push = 1'b1;
          if (!tx_en) begin
            tx_g = `PFC_CG_ESD1;
            tx_st_d = TX_ESD2;
          end else if (tx_er)
            tx_g = `PFC_CG_TXERR;
          else
            tx_g = enc(tx_nibble);
        end
        TX_ESD1: begin
          push = 1'b1;
          tx_g = `PFC_CG_ESD1;
          tx_st_d = TX_ESD2;
        end
        TX_ESD2: begin
          push = 1'b1;
          tx_g = `PFC_CG_ESD2;
          tx_st_d = TX_IDLE;
        end
        default: tx_st_d = TX_IDLE;
      endcase
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst)
      tx_st_q <= TX_IDLE;
    else
      tx_st_q <= tx_st_d;
  end
  pfc_buf2 #(.W(5)) u_buf (
    .clk(clk),
    .rst(rst),
    .in_data(tx_g),
    .in_valid(push),
    .in_ready(b_in_ready),
    .out_data(b_data),
    .out_valid(b_valid),
    .out_ready(take_out)
  );
  // Output stage refills exactly when the buffer pops, so no group is
  // shown twice or lost after a stall
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_group <= `PFC_CG_IDLE;
      tx_group_valid <= 1'b0;
    end else begin
      if (take_out) begin
        tx_group <= b_valid ? b_data : `PFC_CG_IDLE;
        tx_group_valid <= b_valid;
      end
    end
  end

  // Receive
  localparam RX_IDLE = 4'h1;
  localparam RX_SSD = 4'h2;
  localparam RX_DATA = 4'h4;
  localparam RX_ESD = 4'h8;
  reg [3:0] rx_st_q;
  reg [1:0] idle_q;
  reg prev_idle_q;
  wire [4:0] dv = dec(rx_group);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      idle_q <= 2'h0;
      prev_idle_q <= 1'b1;
      rx_nibble <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
    end else if (!active) begin
      rx_st_q <= RX_IDLE;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
    end else if (rx_group_valid) begin
      // Error is a one-group pulse
      rx_er <= 1'b0;
      prev_idle_q <= (rx_group == `PFC_CG_IDLE);
      // Idles in a row, saturating; the second inside a frame ends it
      if (rx_group == `PFC_CG_IDLE && idle_q != `PFC_IDLE_END)
        idle_q <= idle_q + 2'h1;
      else if (rx_group != `PFC_CG_IDLE)
        idle_q <= 2'h0;
      case (rx_st_q)
        RX_IDLE: begin
          rx_dv <= 1'b0;
          // Outside a frame only misplaced delimiters are flagged
          if (rx_group == `PFC_CG_SSD1 && prev_idle_q) begin
            crs <= 1'b1;
            rx_nibble <= `PFC_NIB_SSD;
            rx_st_q <= RX_SSD;
          end else if (rx_group == `PFC_CG_SSD1 ||
                       rx_group == `PFC_CG_SSD2 ||
                       rx_group == `PFC_CG_ESD2) begin
            rx_er <= 1'b1;
          end else
            crs <= 1'b0;
        end
        RX_SSD: begin
          if (rx_group == `PFC_CG_SSD2) begin
            rx_nibble <= `PFC_NIB_SSD;
            rx_dv <= 1'b1;
            rx_st_q <= RX_DATA;
          end else begin
            rx_er <= 1'b1;
            rx_nibble <= `PFC_NIB_BADSSD;
            crs <= 1'b0;
            rx_st_q <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (dv[4])
            rx_nibble <= dv[3:0];
          // End pair is judged on the group after this one
          else if (rx_group == `PFC_CG_ESD1)
            rx_st_q <= RX_ESD;
          else if (rx_group == `PFC_CG_IDLE && idle_q != 2'h0) begin
            rx_dv <= 1'b0;
            crs <= 1'b0;
            rx_st_q <= RX_IDLE;
          end else if (rx_group != `PFC_CG_IDLE)
            rx_er <= 1'b1;
        end
        RX_ESD: begin
          // A lone end group still closes the frame, but flagged
          rx_dv <= 1'b0;
          crs <= 1'b0;
          rx_st_q <= RX_IDLE;
          if (rx_group != `PFC_CG_ESD2)
            rx_er <= 1'b1;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end else
      rx_er <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: tb/pfc_codec_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pfc_codec_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic tx_ready, // Encoder takes nibble
  input wire logic [4:0] tx_group, // Group out
  input wire logic tx_group_valid, // Group valid
  input wire logic tx_group_ready, // Line takes group
  input wire logic [4:0] rx_group, // Group in
  input wire logic rx_group_valid, // Group in valid
  input wire logic [3:0] rx_nibble, // Receive nibble
  input wire logic rx_dv, // Receive valid
  input wire logic rx_er, // Receive error
  input wire logic crs, // Carrier
  input wire logic [4:0] vphy_addr, // Virtual address
  input wire logic path_active // Datapath on
);
  logic [2:0] cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Counts edges after release until the strap is surely latched
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_q <= 3'h0;
    else if (cnt_q != 3'h4)
      cnt_q <= cnt_q + 3'h1;
  end
  sequence s_jk;
    rx_group_valid && rx_group == 5'h1F && !crs ##1
    rx_group_valid && rx_group == 5'h18 ##1 rx_group_valid;
  endsequence
  sequence s_tr;
    rx_dv && rx_group_valid && rx_group == 5'h0D ##1
    rx_group_valid && rx_group == 5'h07;
  endsequence
  a_no_invalid: assert property (tx_group_valid |->
    !(tx_group inside {5'h06, 5'h19, 5'h00})) else $error("bad group");
  a_hold_group: assert property (tx_group_valid && !tx_group_ready
    |=> tx_group_valid && $stable(tx_group)) else $error("group moved");
  a_inactive_block: assert property (!path_active |-> !tx_ready)
    else $error("ready while bypassed");
  a_rxer_cause: assert property (rx_er |-> $past(rx_group_valid))
    else $error("error without group");
  a_strap_hold: assert property (cnt_q == 3'h4 |=> $stable(vphy_addr))
    else $error("address moved");
  a_vphy_range: assert property (vphy_addr inside {5'h00, 5'h01})
    else $error("virtual address range");
  a_ssd_good: assert property (s_jk ##0 rx_group == 5'h11
    |=> rx_dv && rx_nibble == 4'h5) else $error("ssd not decoded");
  a_bad_ssd: assert property (s_jk ##0 rx_group != 5'h11
    |=> rx_er && !rx_dv && rx_nibble == 4'hE) else $error("bad ssd");
  a_esd_end: assert property (s_tr |=> !crs && !rx_dv)
    else $error("carrier kept after end");
endmodule
bind pfc_codec pfc_codec_checker chk_i (.clk, .rst, .tx_ready, .tx_group,
  .tx_group_valid, .tx_group_ready, .rx_group, .rx_group_valid, .rx_nibble,
  .rx_dv, .rx_er, .crs, .vphy_addr, .path_active);
`default_nettype wire

/* File: tb/pfc_codec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pfc_codec_tb_top;
  logic clk, rst, addr_strap_pin, internal_phy_mode, tx_en, tx_er, go;
  logic tx_group_ready, rx_group_valid, addr_wr_p1, addr_wr_p2;
  logic tx_ready, tx_group_valid, rx_dv, rx_er, crs, path_active;
  logic [3:0] tx_nibble, rx_nibble;
  logic [4:0] rx_group, addr_wdata, tx_group, vphy_addr, p1_addr, p2_addr;
  logic [7:0] pe1, pm1, pe2, pm2;
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  int n_errors = 0;
  int cmp_count = 0;
  pfc_codec dut (.clk, .rst, .addr_strap_pin, .internal_phy_mode, .tx_en,
    .tx_er, .tx_nibble, .tx_ready, .tx_group, .tx_group_valid,
    .tx_group_ready, .rx_group, .rx_group_valid, .rx_nibble, .rx_dv, .rx_er,
    .crs, .addr_wr_p1, .addr_wr_p2, .addr_wdata, .vphy_addr, .p1_addr,
    .p2_addr, .path_active);
  pfc_mac_model mac (.clk, .rst, .go, .len(4'h3), .err_at(4'h1), .tx_ready,
    .tx_en, .tx_er, .tx_nibble);
  task chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Outputs of a group show two edges after it is driven
  task rxg(input logic [4:0] g, input logic [7:0] e, m);
    @(posedge clk);
    chk("rx", {8'h0, pm2 & {rx_nibble, 1'b0, rx_dv, rx_er, crs}},
      {8'h0, pm2 & pe2});
    pe2 = pe1;
    pm2 = pm1;
    pe1 = e;
    pm1 = m;
    rx_group <= g;
    rx_group_valid <= |m;
  endtask
  task ssd;
    rxg(5'h1F, 8'h00, 8'h07);
    rxg(5'h18, 8'h51, 8'hF7);
    rxg(5'h11, 8'h55, 8'hF7);
  endtask
  task idle2;
    rxg(5'h1F, 8'h00, 8'h02);
    rxg(5'h1F, 8'h00, 8'h07);
  endtask
  task t_addr;
    #1 chk("addr", {1'b0, vphy_addr, p1_addr, p2_addr}, 16'h0443);
    @(posedge clk);
    addr_strap_pin <= 1'b0;
    addr_wdata <= 5'h07;
    repeat (6) @(posedge clk);
    addr_wr_p1 <= 1'b1;
    addr_wr_p2 <= 1'b1;
    @(posedge clk);
    addr_wr_p1 <= 1'b0;
    addr_wr_p2 <= 1'b0;
    @(posedge clk);
    #1 chk("dup", {1'b0, vphy_addr, p1_addr, p2_addr}, 16'h04E7);
    @(posedge clk);
    addr_wdata <= 5'h09;
    addr_wr_p2 <= 1'b1;
    @(posedge clk);
    addr_wr_p2 <= 1'b0;
    @(posedge clk);
    #1 chk("uniq", {1'b0, vphy_addr, p1_addr, p2_addr}, 16'h04E9);
  endtask
  task t_strap0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("s0", {1'b0, vphy_addr, p1_addr, p2_addr}, 16'h0022);
  endtask
  task t_path;
    @(posedge clk);
    internal_phy_mode <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("off", {14'h0, path_active, tx_ready}, 16'h0);
    @(posedge clk);
    internal_phy_mode <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("on", {9'h0, path_active, tx_group_valid, tx_group}, 16'h7F);
  endtask
  task t_tx;
    logic [4:0] q [8];
    logic [4:0] e [8];
    int n;
    n = 0;
    e = '{5'h18, 5'h11, enc[0], 5'h04, enc[2], 5'h0D, 5'h07, 5'h1F};
    for (int k = 0; k < 300 && n < 8; k++) begin
      @(posedge clk);
      if (tx_group_valid && tx_group_ready && (n > 0 || tx_group != 5'h1F)) begin
        q[n] = tx_group;
        n++;
      end
      go <= (k == 0);
      // Long stall first fills the buffer, then the line takes every other
      tx_group_ready <= (k > 12) && k[0];
    end
    for (int i = 0; i < 8; i++)
      chk("tx", {11'h0, q[i]}, {11'h0, e[i]});
    @(posedge clk);
    tx_group_ready <= 1'b1;
  endtask
  task t_rx;
    ssd;
    for (int i = 0; i < 16; i++)
      rxg(enc[i], {i[3:0], 4'h5}, 8'hF7);
    rxg(5'h06, 8'h02, 8'h02);
    rxg(5'h0D, 8'h00, 8'h02);
    rxg(5'h07, 8'h00, 8'h07);
    ssd;
    idle2;
    rxg(5'h1F, 8'h00, 8'h07);
    rxg(5'h18, 8'h51, 8'hF7);
    rxg(5'h1E, 8'hE2, 8'hF7);
    idle2;
    rxg(5'h07, 8'h02, 8'h02);
    rxg(5'h11, 8'h02, 8'h02);
    idle2;
    ssd;
    rxg(5'h0D, 8'h00, 8'h02);
    rxg(5'h1E, 8'h02, 8'h02);
    idle2;
    rxg(5'h00, 8'h00, 8'h00);
    rxg(5'h00, 8'h00, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
  initial begin
    {rst, addr_strap_pin, internal_phy_mode, tx_group_ready} = 4'hF;
    {go, rx_group_valid, addr_wr_p1, addr_wr_p2} = 4'h0;
    {rx_group, addr_wdata} = 10'h0;
    {pe1, pm1, pe2, pm2} = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_addr;
    t_path;
    t_tx;
    t_rx;
    t_strap0;
    print_verdict;
  end
endmodule
`default_nettype wire

/* File: tb/pfc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfc_mac_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic go, // Start a frame
  input wire logic [3:0] len, // Nibbles in frame
  input wire logic [3:0] err_at, // Nibble sent with error
  input wire logic tx_ready, // Encoder takes nibble
  output logic tx_en, // Transmit enable
  output logic tx_er, // Transmit error
  output logic [3:0] tx_nibble // Nibble value equals its index
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      tx_nibble <= 4'h0;
    end else if (go && !tx_en) begin
      tx_en <= 1'b1;
      tx_er <= (err_at == 4'h0);
      tx_nibble <= 4'h0;
    end else if (tx_en && tx_ready) begin
      // Held until taken, so a slow encoder loses nothing
      tx_en <= (tx_nibble != len - 4'h1);
      tx_er <= (tx_nibble + 4'h1 == err_at);
      tx_nibble <= tx_nibble + 4'h1;
    end
  end
endmodule
`default_nettype wire
